// File: logic/negseq_overcurrent_stage.sv
// negative-sequence overcurrent timing, decision and registers
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module negseq_overcurrent_stage #(
    parameter int MS_CYC = negseq_pkg::MS_CYCLES,
    parameter int DIV_W = 48
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // measured quantity and user block
    input wire logic [15:0] negseq_current_magnitude_in,
    input wire logic mag_valid_in,
    input wire logic user_block_input_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // status outputs
    output logic stage_start_flag_out,
    output logic stage_trip_flag_out,
    output logic general_start_out,
    output logic general_trip_out,
    output logic irq_out
);
    if (MS_CYC < 2 || DIV_W < 44) begin : g_bad_param
        $error("tick length or divider width cannot be served");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_RATIO, ST_PREP_C, ST_CURVE, ST_PREP_S, ST_SCALE
    } seq_t;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] clamp16(input logic [31:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        if (v < {16'h0000, lo}) begin
            return lo;
        end
        if (v > {16'h0000, hi}) begin
            return hi;
        end
        return v[15:0];
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // curve k in microseconds, indexed by mode
    function automatic logic [26:0] curve_k(input logic [3:0] m);
        case (m)
            4'h2: return 27'h002_22E0;
            4'h3: return 27'h0CD_FE60;
            4'h4: return 27'h4C4_B400;
            4'h5: return 27'h727_0E00;
            4'h6: return 27'h000_2198;
            4'h7: return 27'h000_C92C;
            4'h8: return 27'h12B_3990;
            4'h9: return 27'h1AE_4C40;
            4'hA: return 27'h001_4FF0;
            4'hB: return 27'h1B3_A370;
            4'hC: return 27'h3D1_A170;
            default: return 27'h000_0000;
        endcase
    endfunction

    // curve c in microseconds
    function automatic logic [19:0] curve_c(input logic [3:0] m);
        case (m)
            4'h6: return 20'h0_4844;
            4'h7: return 20'h1_BD50;
            4'h8: return 20'h7_7DF8;
            4'h9: return 20'h1_DB64;
            4'hA: return 20'h2_D2A8;
            4'hB: return 20'hA_DD40;
            4'hC: return 20'h3_D090;
            default: return 20'h0_0000;
        endcase
    endfunction

    // exponent class: 0 is 0.02, 1 is 1, 2 is 2
    function automatic logic [1:0] curve_a(input logic [3:0] m);
        case (m)
            4'h3, 4'h5: return 2'h1;
            4'h4, 4'h8, 4'h9, 4'hB, 4'hC: return 2'h2;
            default: return 2'h0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // settings and register writes
    // ----------------------------------------------------------------
    logic [3:0] operation_mode_setting;
    logic [15:0] start_current_setting;
    logic [15:0] time_multiplier_setting;
    logic [15:0] min_delay_setting;
    logic [15:0] fixed_delay_setting;
    logic [15:0] reset_delay_setting;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;

    wire wr_mode = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_MODE);
    wire wr_start = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_START);
    wire wr_mult = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_MULT);
    wire wr_min = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_MIN_DLY);
    wire wr_fix = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_FIX_DLY);
    wire wr_rdly = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_RST_DLY);
    wire wr_clr = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_IRQ_CLR);
    wire wr_en = reg_wr_in && hit(reg_addr_in, negseq_pkg::REG_IRQ_EN);
    wire mode_ok = reg_wdata_in[31:0] <= {28'h000_0000, negseq_pkg::MODE_LAST};

    // out-of-range values are clamped, and an out-of-range mode write is ignored, so the timer never sees them
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            operation_mode_setting <= negseq_pkg::MODE_OFF;
            start_current_setting <= negseq_pkg::START_RST;
            time_multiplier_setting <= negseq_pkg::MULT_RST;
            min_delay_setting <= negseq_pkg::DLY_RST;
            fixed_delay_setting <= negseq_pkg::DLY_RST;
            reset_delay_setting <= negseq_pkg::DLY_RST;
            irq_en <= 2'h0;
        end else if (ce_in) begin
            if (wr_mode && mode_ok) begin
                operation_mode_setting <= reg_wdata_in[3:0];
            end
            if (wr_start) begin
                start_current_setting <= clamp16(reg_wdata_in,
                    negseq_pkg::START_MIN, negseq_pkg::START_MAX);
            end
            if (wr_mult) begin
                time_multiplier_setting <= clamp16(reg_wdata_in,
                    negseq_pkg::MULT_MIN, negseq_pkg::MULT_MAX);
            end
            if (wr_min) begin
                min_delay_setting <= clamp16(reg_wdata_in,
                    negseq_pkg::DLY_MIN, negseq_pkg::DLY_MAX);
            end
            if (wr_fix) begin
                fixed_delay_setting <= clamp16(reg_wdata_in,
                    negseq_pkg::DLY_MIN, negseq_pkg::DLY_MAX);
            end
            if (wr_rdly) begin
                reset_delay_setting <= clamp16(reg_wdata_in,
                    negseq_pkg::RDLY_MIN, negseq_pkg::DLY_MAX);
            end
            if (wr_en) begin
                irq_en <= reg_wdata_in[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // mode decode and start decision
    // ----------------------------------------------------------------
    logic [15:0] g_q;
    logic start_q;
    logic trip_q;
    wire active = operation_mode_setting != negseq_pkg::MODE_OFF
                  && !user_block_input_in;
    wire is_dt = operation_mode_setting == negseq_pkg::MODE_DT;
    wire is_inv = active && !is_dt;
    wire is_iec = operation_mode_setting <= negseq_pkg::MODE_IEC_LONG;
    wire [20:0] g_drop = 21'(g_q) * 21'(negseq_pkg::DROP_DEN);
    wire [20:0] s_drop = 21'(start_current_setting) * 21'(negseq_pkg::DROP_NUM);
    wire pick = g_q > start_current_setting;
    wire drop = g_drop < s_drop; // reset ratio 0.95 avoids chatter
    wire next_start = active && (pick || (start_q && !drop));

    // latch each new magnitude from the upstream calculation
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            g_q <= 16'h0000;
            start_q <= 1'b0;
        end else if (ce_in) begin
            if (mag_valid_in) begin
                g_q <= negseq_current_magnitude_in;
            end
            start_q <= next_start;
        end
    end

    // ----------------------------------------------------------------
    // inverse characteristic arithmetic
    // ----------------------------------------------------------------
    div_bus_if #(.W(DIV_W)) div_bus ();
    seq_t seq;
    logic div_req;
    logic [20:0] m_q;
    logic [31:0] tus_q;
    logic [15:0] inv_dly_q;

    // ratio is clamped at twenty times the setting
    wire [15:0] g_lim = 16'(start_current_setting * negseq_pkg::CLAMP_RATIO);
    wire [15:0] g_c = g_q > g_lim ? g_lim : g_q;

    // log2 of the ratio: leading one plus a parabolic mantissa fix
    logic [4:0] msb;
    always_comb begin
        msb = 5'h00;
        for (int i = 0; i < 21; i++) begin
            if (m_q[i]) begin
                msb = 5'(i);
            end
        end
    end
    wire [41:0] m_norm = 42'(m_q) << (5'h14 - msb);
    wire [15:0] frac = m_norm[19:4];
    wire [31:0] fpart = (32'(frac) * (32'h0001_0000 - 32'(frac))) >> 16;
    wire [31:0] fcorr = 32'((48'(fpart) * 48'(negseq_pkg::LOG_CORR)) >> 16);
    wire [31:0] lg2 = ({27'h000_0000, msb - 5'h10} << 16) + 32'(frac) + fcorr;

    // power term minus one, Q16
    wire [41:0] m_sq = 42'(m_q) * 42'(m_q);
    wire [31:0] x_a0 = 32'((48'(lg2) * 48'(negseq_pkg::LN2_ALPHA)) >> 16);
    wire [31:0] x_a1 = 32'(m_q) - negseq_pkg::ONE_Q16;
    wire [31:0] x_a2 = 32'(m_sq >> 16) - negseq_pkg::ONE_Q16;
    wire [1:0] a_cls = curve_a(operation_mode_setting);
    wire [31:0] x_raw = a_cls == 2'h2 ? x_a2 : (a_cls == 2'h1 ? x_a1 : x_a0);
    wire [31:0] x_term = x_raw == 32'h0000_0000 ? 32'h0000_0001 : x_raw;

    // operands by phase of the sequence
    always_comb begin
        case (seq)
            ST_RATIO: begin
                div_bus.numer = DIV_W'({g_c, 16'h0000});
                div_bus.denom = DIV_W'(start_current_setting);
            end
            ST_CURVE: begin
                div_bus.numer = DIV_W'({curve_k(operation_mode_setting), 16'h0000});
                div_bus.denom = DIV_W'(x_term);
            end
            default: begin
                div_bus.numer = DIV_W'(48'(tus_q) * 48'(time_multiplier_setting));
                div_bus.denom = DIV_W'(negseq_pkg::SCALE_DIV);
            end
        endcase
    end
    assign div_bus.req = div_req;

    seq_divider #(.W(DIV_W)) u_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .bus(div_bus)
    );

    wire quo_big = |div_bus.quot[DIV_W-1:32];
    wire [31:0] quo32 = quo_big ? 32'hFFFF_FFFF : div_bus.quot[31:0];
    wire [32:0] t_sum = 33'(quo32) + 33'(curve_c(operation_mode_setting));
    wire [15:0] t_ms = quo_big || (|quo32[31:16]) ? 16'hFFFF : quo32[15:0];
    wire [15:0] t_lim = t_ms < min_delay_setting ? min_delay_setting : t_ms;

    // a fresh sample in an inverse mode starts ratio, curve and scaling divisions if the sequence is idle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            seq <= ST_IDLE;
            div_req <= 1'b0;
            m_q <= 21'h00_0000;
            tus_q <= 32'h0000_0000;
            inv_dly_q <= negseq_pkg::INV_DLY_RST;
        end else if (ce_in) begin
            div_req <= 1'b0;
            case (seq)
                ST_IDLE: begin
                    if (mag_valid_in && is_inv) begin
                        seq <= ST_RATIO;
                        div_req <= 1'b1;
                    end
                end
                ST_RATIO: begin
                    if (div_bus.done) begin
                        m_q <= 21'(div_bus.quot);
                        seq <= ST_PREP_C;
                    end
                end
                ST_PREP_C: begin
                    seq <= ST_CURVE;
                    div_req <= 1'b1;
                end
                ST_CURVE: begin
                    if (div_bus.done) begin
                        tus_q <= t_sum[32] ? 32'hFFFF_FFFF : t_sum[31:0];
                        seq <= ST_PREP_S;
                    end
                end
                ST_PREP_S: begin
                    seq <= ST_SCALE;
                    div_req <= 1'b1;
                end
                ST_SCALE: begin
                    if (div_bus.done) begin
                        inv_dly_q <= t_lim;
                        seq <= ST_IDLE;
                    end
                end
                default: begin
                    seq <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // delay accumulator and trip
    // ----------------------------------------------------------------
    logic [31:0] ms_cnt;
    logic [15:0] acc;
    logic [15:0] rst_cnt;
    wire ms_tick = ms_cnt == 32'(MS_CYC - 1);
    wire [15:0] delay_ms = is_dt ? fixed_delay_setting : inv_dly_q;
    wire next_trip = next_start && acc >= delay_ms;

    // one millisecond step keeps the error well inside 15 ms
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ms_cnt <= 32'h0000_0000;
            acc <= 16'h0000;
            rst_cnt <= 16'h0000;
            trip_q <= 1'b0;
        end else if (ce_in) begin
            ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
            trip_q <= next_trip;
            if (!active) begin
                acc <= 16'h0000;
                rst_cnt <= 16'h0000;
            end else if (start_q) begin
                rst_cnt <= 16'h0000;
                if (ms_tick && acc < delay_ms) begin
                    acc <= acc + 16'h0001;
                end
            end else if (is_iec && !is_dt && acc != 16'h0000) begin
                if (ms_tick) begin
                    rst_cnt <= rst_cnt + 16'h0001;
                    if (rst_cnt + 16'h0001 >= reset_delay_setting) begin
                        acc <= 16'h0000;
                        rst_cnt <= 16'h0000;
                    end
                end
            end else begin
                acc <= 16'h0000;
                rst_cnt <= 16'h0000;
            end
        end
    end

    assign stage_start_flag_out = start_q;
    assign stage_trip_flag_out = trip_q;
    assign general_start_out = start_q;
    assign general_trip_out = trip_q;

    // ----------------------------------------------------------------
    // interrupts and read-back
    // ----------------------------------------------------------------
    logic [1:0] flags_d;
    wire [1:0] rise = {trip_q, start_q} & ~flags_d;
    wire [1:0] clr_mask = wr_clr ? reg_wdata_in[1:0] : 2'h0;
    wire [1:0] next_irq_stat = (irq_stat & ~clr_mask) | rise; // set beats clear
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr_in)
            negseq_pkg::REG_MODE: rd_mux = 32'(operation_mode_setting);
            negseq_pkg::REG_START: rd_mux = 32'(start_current_setting);
            negseq_pkg::REG_MULT: rd_mux = 32'(time_multiplier_setting);
            negseq_pkg::REG_MIN_DLY: rd_mux = 32'(min_delay_setting);
            negseq_pkg::REG_FIX_DLY: rd_mux = 32'(fixed_delay_setting);
            negseq_pkg::REG_RST_DLY: rd_mux = 32'(reset_delay_setting);
            negseq_pkg::REG_STATE: begin
                rd_mux[negseq_pkg::BIT_START] = start_q;
                rd_mux[negseq_pkg::BIT_TRIP] = trip_q;
            end
            negseq_pkg::REG_DELAY: rd_mux = {acc, delay_ms};
            negseq_pkg::REG_IRQ_STAT: rd_mux = 32'(irq_stat);
            negseq_pkg::REG_IRQ_EN: rd_mux = 32'(irq_en);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flags_d <= 2'h0;
            irq_stat <= 2'h0;
            irq_out <= 1'b0;
            reg_rdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            flags_d <= {trip_q, start_q};
            irq_stat <= next_irq_stat;
            irq_out <= |(next_irq_stat & irq_en);
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end
endmodule

// File: include/negseq_pkg.sv
// constants shared by the negative-sequence overcurrent stage
package negseq_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_START = 8'h04;
    localparam logic [7:0] REG_MULT = 8'h08;
    localparam logic [7:0] REG_MIN_DLY = 8'h0C;
    localparam logic [7:0] REG_FIX_DLY = 8'h10;
    localparam logic [7:0] REG_RST_DLY = 8'h14;
    localparam logic [7:0] REG_STATE = 8'h18;
    localparam logic [7:0] REG_DELAY = 8'h1C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h20;
    localparam logic [7:0] REG_IRQ_CLR = 8'h24;
    localparam logic [7:0] REG_IRQ_EN = 8'h28;

    // ----------------------------------------------------------------
    // field positions (state and interrupt registers share them)
    // ----------------------------------------------------------------
    localparam int BIT_START = 0;
    localparam int BIT_TRIP = 1;

    // ----------------------------------------------------------------
    // operation modes
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_DT = 4'h1;
    localparam logic [3:0] MODE_IEC_LONG = 4'h5;
    localparam logic [3:0] MODE_LAST = 4'hC;

    // ----------------------------------------------------------------
    // setting ranges and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] START_MIN = 16'h000A;
    localparam logic [15:0] START_MAX = 16'h03E8;
    localparam logic [15:0] START_RST = 16'h0032;
    localparam logic [15:0] MULT_MIN = 16'h0005;
    localparam logic [15:0] MULT_MAX = 16'h05DC;
    localparam logic [15:0] MULT_RST = 16'h0064;
    localparam logic [15:0] DLY_MIN = 16'h0028;
    localparam logic [15:0] RDLY_MIN = 16'h003C;
    localparam logic [15:0] DLY_MAX = 16'hEA60;
    localparam logic [15:0] DLY_RST = 16'h0064;
    localparam logic [15:0] INV_DLY_RST = 16'hFFFF;

    // ----------------------------------------------------------------
    // arithmetic constants
    // ----------------------------------------------------------------
    localparam logic [15:0] CLAMP_RATIO = 16'h0014;
    localparam logic [4:0] DROP_NUM = 5'h13;
    localparam logic [4:0] DROP_DEN = 5'h14;
    localparam logic [31:0] ONE_Q16 = 32'h0001_0000;
    localparam logic [15:0] LN2_ALPHA = 16'h038C;
    localparam logic [15:0] LOG_CORR = 16'h5709;
    localparam logic [47:0] SCALE_DIV = 48'h0000_0001_86A0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int MS_CYCLES = TICK_NS / CLK_PERIOD_NS;

endpackage

// File: include/div_bus_if.sv
// request and answer lines between the stage and its divider
`timescale 1ns/1ps
interface div_bus_if #(parameter int W = 48);
    logic req;
    logic [W-1:0] numer;
    logic [W-1:0] denom;
    logic [W-1:0] quot;
    logic done;
    modport client (output req, output numer, output denom, input quot, input done);
    modport server (input req, input numer, input denom, output quot, output done);
endinterface

// File: logic/seq_divider.sv
// bit-serial restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
module seq_divider #(
    parameter int W = 48
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // request and answer
    div_bus_if.server bus
);
    if (W < 2) begin : g_bad_w
        $error("divider width too small");
    end

    logic [W:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] den;
    logic [7:0] cnt;
    logic done;
    wire [W:0] shifted = {rem[W-1:0], quo[W-1]};
    wire fits = shifted >= {1'b0, den};

    // a zero divisor yields all ones, which later saturates
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rem <= '0;
            quo <= '0;
            den <= '0;
            cnt <= 8'h00;
            done <= 1'b0;
        end else if (ce_in) begin
            done <= 1'b0;
            if (bus.req) begin
                rem <= '0;
                quo <= bus.numer;
                den <= bus.denom;
                cnt <= 8'(W);
            end else if (cnt != 8'h00) begin
                rem <= fits ? shifted - {1'b0, den} : shifted;
                quo <= {quo[W-2:0], fits};
                cnt <= cnt - 8'h01;
                done <= cnt == 8'h01;
            end
        end
    end

    assign bus.quot = quo;
    assign bus.done = done;
endmodule

// File: tb/negseq_asserts.sv
// port assertions for the overcurrent stage
`timescale 1ns/1ps
module negseq_asserts (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // inputs
    input wire logic user_block_input_in,
    input wire logic mag_valid_in,
    input wire logic [15:0] negseq_current_magnitude_in,
    input wire logic reg_rd_in,
    // outputs
    input wire logic [31:0] reg_rdata_out,
    input wire logic stage_start_flag_out,
    input wire logic stage_trip_flag_out,
    input wire logic general_start_out,
    input wire logic general_trip_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ----------------
    // properties
    // ----------------
    gen_start_a:
    assert property (general_start_out == stage_start_flag_out) else $error("gen start");
    gen_trip_a:
    assert property (general_trip_out == stage_trip_flag_out) else $error("gen trip");
    block_start_a:
    assert property (user_block_input_in |=> !stage_start_flag_out) else $error("blk st");
    block_trip_a:
    assert property (user_block_input_in |=> !stage_trip_flag_out) else $error("blk tr");
    trip_start_a:
    assert property (stage_trip_flag_out |-> stage_start_flag_out) else $error("tr no st");
    no_early_a:
    assert property ($rose(stage_start_flag_out) |-> !stage_trip_flag_out) else $error("early");
    rdata_idle_a:
    assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000) else $error("rdata");
    zero_mag_a:
    assert property (mag_valid_in && negseq_current_magnitude_in == 16'h0000
        |-> ##2 !stage_start_flag_out) else $error("zero st");
    // main scenarios seen
    cover property ($rose(stage_start_flag_out));
    cover property ($rose(stage_trip_flag_out));
    cover property ($rose(irq_out));
endmodule

// File: tb/magnitude_source.sv
// upstream magnitude source, one sample each 64 cycles
`timescale 1ns/1ps
module magnitude_source (
    // clock and level
    input wire logic clk_in,
    input wire logic [15:0] level_in,
    // sample out
    output logic [15:0] mag_out = 16'h0000,
    output logic valid_out = 1'b0
);
    logic [5:0] gap = 6'h00;
    // the 64-cycle spacing is shorter than the three divisions, so samples arriving during a computation are skipped
    always @(posedge clk_in) begin
        gap <= gap + 6'h01;
        valid_out <= (gap == 6'h3F);
        mag_out <= level_in;
    end
endmodule

// File: tb/negseq_overcurrent_stage_tb.sv
// self-checking bench for the overcurrent stage
`timescale 1ns/1ps
module negseq_overcurrent_stage_tb;
    localparam int MS = 20; // short millisecond keeps the run small
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic blk = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [15:0] level = 16'h0000;
    logic [15:0] mag;
    logic valid;
    logic [31:0] rdata;
    logic [31:0] q;
    logic st, tr, gs, gt, irq;
    int errors = 0;
    int num_checks = 0;
    int n;
    always #5 clk_in = ~clk_in;
    magnitude_source u_magnitude_source (.clk_in(clk_in), .level_in(level),
        .mag_out(mag), .valid_out(valid));
    negseq_overcurrent_stage #(.MS_CYC(MS)) u_negseq_overcurrent_stage (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .ce_in(1'b1), .negseq_current_magnitude_in(mag),
        .mag_valid_in(valid), .user_block_input_in(blk), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .stage_start_flag_out(st), .stage_trip_flag_out(tr), .general_start_out(gs),
        .general_trip_out(gt), .irq_out(irq));
    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, k = 32'hFFFF_FFFF);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 q = rdata;
        chk("reg", q & k, e);
    endtask
    // waits for trip, the count bounded so a hang cannot stall the bench
    task automatic wait_trip();
        n = 0;
        while (tr !== 1'b1 && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
    endtask
    task automatic wait_st();
        for (int i = 0; i < 300 && st !== 1'b1; i++) @(posedge clk_in);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_regs();
        rchk(negseq_pkg::REG_MODE, 32'h0000_0000);
        rchk(negseq_pkg::REG_START, 32'h0000_0032);
        rchk(negseq_pkg::REG_MULT, 32'h0000_0064);
        rchk(negseq_pkg::REG_MIN_DLY, 32'h0000_0064);
        rchk(negseq_pkg::REG_RST_DLY, 32'h0000_0064);
        wreg(negseq_pkg::REG_START, 32'h0000_0005);
        rchk(negseq_pkg::REG_START, 32'h0000_000A);
        wreg(negseq_pkg::REG_MULT, 32'h0000_05DD);
        rchk(negseq_pkg::REG_MULT, 32'h0000_05DC);
        wreg(negseq_pkg::REG_FIX_DLY, 32'h0000_EA61);
        rchk(negseq_pkg::REG_FIX_DLY, 32'h0000_EA60);
        wreg(negseq_pkg::REG_RST_DLY, 32'h0000_003B);
        rchk(negseq_pkg::REG_RST_DLY, 32'h0000_003C);
        for (int m = 0; m < 14; m++) begin
            wreg(negseq_pkg::REG_MODE, m);
            rchk(negseq_pkg::REG_MODE, (m > 12) ? 12 : m);
        end
        rchk(8'h30, 32'h0000_0000);
    endtask
    task automatic t_dt();
        wreg(negseq_pkg::REG_MODE, 32'h0000_0001);
        wreg(negseq_pkg::REG_START, 32'h0000_0032);
        wreg(negseq_pkg::REG_FIX_DLY, 32'h0000_0028);
        wreg(negseq_pkg::REG_IRQ_EN, 32'h0000_0003);
        level <= 16'h0064;
        wait_st();
        wait_trip();
        chk("dt time", (n > 25 * MS && n < 55 * MS), 1);
        chk("gen", {gs, gt, irq}, 3'b111);
        rchk(negseq_pkg::REG_IRQ_STAT, 32'h0000_0003);
        wreg(negseq_pkg::REG_IRQ_CLR, 32'h0000_0003);
        rchk(negseq_pkg::REG_IRQ_STAT, 32'h0000_0000);
        chk("irq", irq, 1'b0);
    endtask
    task automatic t_block();
        blk <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("blk", {st, tr}, 2'b00);
        rchk(negseq_pkg::REG_DELAY, {16'h0000, 16'h0028});
        blk <= 1'b0;
        wait_st();
        wreg(negseq_pkg::REG_MODE, 32'h0000_0000);
        repeat (2) @(posedge clk_in);
        chk("off", st, 1'b0);
    endtask
    task automatic t_inv();
        wreg(negseq_pkg::REG_MODE, 32'h0000_0003);
        wreg(negseq_pkg::REG_MULT, 32'h0000_0064);
        wreg(negseq_pkg::REG_MIN_DLY, 32'h0000_0028);
        level <= 16'h03E8;
        repeat (500) @(posedge clk_in);
        rchk(negseq_pkg::REG_DELAY, 32'h0000_02C6, 32'h0000_FFFF);
        level <= 16'h07D0;
        repeat (500) @(posedge clk_in);
        rchk(negseq_pkg::REG_DELAY, 32'h0000_02C6, 32'h0000_FFFF);
        wreg(negseq_pkg::REG_MULT, 32'h0000_0005);
        wreg(negseq_pkg::REG_MIN_DLY, 32'h0000_0064);
        repeat (500) @(posedge clk_in);
        rchk(negseq_pkg::REG_DELAY, 32'h0000_0064, 32'h0000_FFFF);
        wait_trip();
        chk("inv trip", tr, 1'b1);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_dt();
        t_block();
        t_inv();
        wrap_up();
    end
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule
bind negseq_overcurrent_stage negseq_asserts u_negseq_asserts (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .user_block_input_in(user_block_input_in),
    .mag_valid_in(mag_valid_in), .negseq_current_magnitude_in(negseq_current_magnitude_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .stage_start_flag_out(stage_start_flag_out), .stage_trip_flag_out(stage_trip_flag_out),
    .general_start_out(general_start_out), .general_trip_out(general_trip_out),
    .irq_out(irq_out));
